// >>> dv/ctgs_engine_model.sv
// ctgs_engine_model: acquisition engine stand-in, one frame per frame start pulse.
// assumes frmGo is the frame start pulse; ovrEn forces the flags.
`timescale 1ns/1ps
module ctgs_engine_model #(
    parameter int FRM_LEN = 20,
    parameter int EXP_LEN = 8
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       frmGo,
    input  wire logic       armed,
    input  wire logic       ovrEn,
    input  wire logic [5:0] ovr,
    output logic      [5:0] flags
);
    int cnt_ff;
    // a start pulse during a frame is ignored, as the real engine would
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            cnt_ff <= 0;
        else if (frmGo && cnt_ff == 0)
            cnt_ff <= FRM_LEN;
        else if (cnt_ff != 0)
            cnt_ff <= cnt_ff - 1;
    end
    // bit order follows the status selector codes
    assign flags = ovrEn ? ovr : {cnt_ff > FRM_LEN - EXP_LEN, cnt_ff != 0,
                                  armed && cnt_ff == 0, 1'b0, armed, 1'b0};
endmodule // ctgs_engine_model

// >>> dv/ctgs_trigger_gen_props.sv
// ctgs_trigger_gen_props: port-level checks on ctgs_trigger_gen.
// assumes one clock domain; bound to every instance by name.
`timescale 1ns/1ps
module ctgs_trigger_gen_props (
    input wire logic                     clk_sys,
    input wire logic                     reset,
    input wire logic                     cfgWrite,
    input ctgs_pkg::ctgs_trig_type       trigTypePick,
    input wire logic                     trigEnable,
    input wire logic [7:0]               trigInputPick,
    input wire logic [15:0]              trigWaitTime,
    input wire logic [7:0]               trigDiv,
    input wire logic [7:0]               trigMul,
    input wire logic                     swFire,
    input wire logic                     acqStartCmd,
    input wire logic                     acqStopCmd,
    input wire logic                     acqWaitFlag,
    input wire logic                     acqRunning,
    input wire logic                     acqXferFlag,
    input wire logic                     frmWaitFlag,
    input wire logic                     frmRunning,
    input wire logic                     exposing,
    input ctgs_pkg::ctgs_status_type     acqStatePick,
    input wire logic [12:0]              trigPulse,
    input wire logic [12:0]              trigLevel,
    input wire logic                     acqArmed,
    input wire logic                     acqStateFlag
);
    import ctgs_pkg::*;
    logic [12:0] en_ff, e1_ff, e2_ff, e3_ff;
    logic        rowPlain_ff;
    wire logic [7:0] stv = {2'b00, exposing, frmRunning, frmWaitFlag, acqXferFlag,
                            acqRunning, acqWaitFlag};
    // shadow enables, delayed so in-flight pulses after a disable are tolerated
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            en_ff <= '0;
            e1_ff <= '0;
            e2_ff <= '0;
            e3_ff <= '0;
            rowPlain_ff <= 1'b0;
        end else begin
            e1_ff <= en_ff;
            e2_ff <= e1_ff;
            e3_ff <= e2_ff;
            if (cfgWrite)
                en_ff[trigTypePick] <= trigEnable;
            if (cfgWrite && trigTypePick == CTGS_ROW_BEGIN)
                rowPlain_ff <= trigEnable && trigInputPick == 8'h00 && trigWaitTime == 16'h0000
                               && trigDiv <= 8'h01 && trigMul <= 8'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_quiet;
        !(swFire && trigTypePick == CTGS_ROW_BEGIN) [*3];
    endsequence
    sequence s_hit;
        acqArmed && rowPlain_ff && swFire && trigTypePick == CTGS_ROW_BEGIN;
    endsequence
    property p_arm; acqStartCmd |=> acqArmed; endproperty
    property p_disarm; acqStopCmd && !acqStartCmd |=> !acqArmed; endproperty
    property p_hold; !acqStartCmd && !acqStopCmd |=> $stable(acqArmed); endproperty
    property p_gate; !acqArmed ##1 !acqArmed |-> trigPulse == '0 && trigLevel == '0; endproperty
    property p_status; !$past(reset) |-> acqStateFlag == $past(stv[acqStatePick]); endproperty
    property p_xfer_old; acqStatePick == CTGS_ST_FRM_XFER_OLD |=> !acqStateFlag; endproperty
    property p_off; (trigPulse & ~(en_ff | e1_ff | e2_ff | e3_ff)) == '0; endproperty
    property p_sw_row;
        s_quiet ##1 s_hit |-> ##4 trigPulse[CTGS_ROW_BEGIN] ##1 !trigPulse[CTGS_ROW_BEGIN];
    endproperty
    a_arm: assert property (p_arm) else $error("arm command did not arm");
    a_disarm: assert property (p_disarm) else $error("stop command did not disarm");
    a_hold: assert property (p_hold) else $error("armed state moved by itself");
    a_gate: assert property (p_gate) else $error("trigger output while disarmed");
    a_status: assert property (p_status) else $error("status flag wrong");
    a_xfer_old: assert property (p_xfer_old) else $error("retired status not zero");
    a_off: assert property (p_off) else $error("pulse from disabled type");
    a_sw_row: assert property (p_sw_row) else $error("software pulse late or long");
endmodule // ctgs_trigger_gen_props
bind ctgs_trigger_gen ctgs_trigger_gen_props u_props (.*);

// >>> dv/tb.sv
// tb: self-checking bench for ctgs_trigger_gen beside an acquisition engine stand-in.
// assumes default source counts, so line 0 is code 1 and counter start 0 is code 5.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
module tb;
    import ctgs_pkg::*;
    logic             clk_sys = 1'b0, reset = 1'b1, cfgWrite = 1'b0, trigEnable = 1'b0;
    logic             swFire = 1'b0, acqStartCmd = 1'b0, acqStopCmd = 1'b0, ovrEn = 1'b0;
    logic [7:0]       trigInputPick = 8'h00, trigDiv = 8'h01, trigMul = 8'h01;
    logic [15:0]      trigWaitTime = 16'h0000;
    logic [3:0]       lineIn = 4'h0;
    logic [1:0]       cntStart = 2'h0;
    logic [5:0]       ovr = 6'h00, flags;
    logic [12:0]      trigPulse, trigLevel;
    logic             acqArmed, acqStateFlag;
    ctgs_trig_type    trigTypePick = CTGS_ACQ_BEGIN;
    ctgs_sense_type   trigSense = CTGS_SENSE_RISE;
    ctgs_overlap_type trigOverlapPolicy = CTGS_OVERLAP_OFF;
    ctgs_status_type  acqStatePick = CTGS_ST_ACQ_WAIT;
    int               n_fail = 0, n_checks = 0, b;
    int               pc[13] = '{default: 0};
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        for (int i = 0; i < 13; i++)
            if (trigPulse[i] === 1'b1)
                pc[i]++;
    end
    ctgs_trigger_gen uut (.clk_sys(clk_sys), .reset(reset), .cfgWrite(cfgWrite),
        .trigTypePick(trigTypePick), .trigEnable(trigEnable), .trigInputPick(trigInputPick),
        .trigSense(trigSense), .trigWaitTime(trigWaitTime), .trigDiv(trigDiv),
        .trigMul(trigMul), .trigOverlapPolicy(trigOverlapPolicy), .swFire(swFire),
        .acqStartCmd(acqStartCmd), .acqStopCmd(acqStopCmd), .lineIn(lineIn),
        .cntStart(cntStart), .cntEnd(2'h0), .tmrStart(2'h0), .tmrEnd(2'h0), .userOut(4'h0),
        .actionIn(2'h0), .acqWaitFlag(flags[0]), .acqRunning(flags[1]),
        .acqXferFlag(flags[2]), .frmWaitFlag(flags[3]), .frmRunning(flags[4]),
        .exposing(flags[5]), .acqStatePick(acqStatePick), .trigPulse(trigPulse),
        .trigLevel(trigLevel), .acqArmed(acqArmed), .acqStateFlag(acqStateFlag));
    ctgs_engine_model far (.clk_sys(clk_sys), .reset(reset), .frmGo(trigPulse[6]),
        .armed(acqArmed), .ovrEn(ovrEn), .ovr(ovr), .flags(flags));
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic cfg(input int t, e, s, se, w, d, m, po);
        wt(1);
        trigTypePick = ctgs_trig_type'(t);
        trigEnable = e[0];
        trigInputPick = 8'(s);
        trigSense = ctgs_sense_type'(se);
        trigWaitTime = 16'(w);
        trigDiv = 8'(d);
        trigMul = 8'(m);
        trigOverlapPolicy = ctgs_overlap_type'(po);
        cfgWrite = 1'b1;
        wt(1);
        cfgWrite = 1'b0;
    endtask
    task automatic fire(input int t);
        wt(1);
        trigTypePick = ctgs_trig_type'(t);
        swFire = 1'b1;
        wt(1);
        swFire = 1'b0;
    endtask
    // pulse must be absent one edge early and present at edge n
    task automatic see(input int i, n);
        wt(n - 1);
        `CHK(trigPulse[i], 1'b0)
        wt(1);
        `CHK(trigPulse[i], 1'b1)
    endtask
    task automatic arm(input logic on);
        wt(1);
        acqStartCmd = on;
        acqStopCmd = !on;
        wt(1);
        acqStartCmd = 1'b0;
        acqStopCmd = 1'b0;
        `CHK(acqArmed, on)
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        complete_run();
    end
    initial begin
        wt(4);
        reset = 1'b0;
        `CHK(trigPulse, 13'h0000)
        cfg(9, 1, 0, 0, 0, 1, 1, 0);
        b = pc[9];
        fire(9);
        wt(6);
        `CHK(pc[9], b)
        arm(1'b1);
        for (int t = 0; t < 13; t++) begin
            cfg(t, 1, 0, 0, 0, 1, 1, 0);
            fire(t);
            see(t, 3);
            wt(25);
        end
        cfg(9, 0, 0, 0, 0, 1, 1, 0);
        b = pc[9];
        fire(9);
        wt(6);
        `CHK(pc[9], b)
        cfg(9, 1, 1, 0, 0, 1, 1, 0);
        fire(9);
        wt(6);
        `CHK(pc[9], b)
        cfg(12, 1, 0, 0, 5, 1, 3, 0);
        fire(12);
        see(12, 8);
        wt(1);
        `CHK(trigPulse[12], 1'b1)
        wt(1);
        `CHK(trigPulse[12], 1'b1)
        wt(1);
        `CHK(trigPulse[12], 1'b0)
        cfg(11, 1, 0, 0, 0, 3, 1, 0);
        b = pc[11];
        repeat (6) begin
            fire(11);
            wt(5);
        end
        `CHK(pc[11] - b, 2)
        for (int s = 0; s < 5; s++) begin
            cfg(0, 1, 1, s, 0, 1, 1, 0);
            wt(4);
            b = pc[0];
            lineIn[0] = 1'b1;
            if (s == 0)
                see(0, 5);
            wt(8);
            `CHK(trigLevel[0], s == 3)
            lineIn[0] = 1'b0;
            wt(8);
            `CHK(trigLevel[0], s == 4)
            `CHK(pc[0] - b, s == 2 ? 2 : 1)
        end
        cfg(1, 1, 5, 0, 0, 1, 1, 0);
        b = pc[1];
        cntStart[0] = 1'b1;
        wt(1);
        cntStart[0] = 1'b0;
        wt(5);
        `CHK(pc[1] - b, 1)
        // second hit lands mid frame: dropped, passed after exposure, or held
        for (int p = 0; p < 3; p++) begin
            cfg(6, 1, 0, 0, 0, 1, 1, p);
            b = pc[6];
            fire(6);
            wt(p == 1 ? 12 : 4);
            fire(6);
            wt(40);
            `CHK(pc[6] - b, p == 0 ? 1 : 2)
        end
        ovrEn = 1'b1;
        for (int p = 0; p < 7; p++)
            for (int f = 0; f < 6; f++) begin
                acqStatePick = ctgs_status_type'(p);
                ovr = 6'(1 << f);
                wt(2);
                `CHK(acqStateFlag, p == f)
            end
        ovrEn = 1'b0;
        arm(1'b0);
        b = pc[10];
        fire(10);
        wt(6);
        `CHK(pc[10], b)
        complete_run();
    end
endmodule // tb

// >>> logic/ctgs_pkg.sv
// ctgs_pkg: shared types and constants for the camera trigger generator and status block.
// assumes one system clock; all users import the whole package.
package ctgs_pkg;

    // trigger types, one independent channel each
    typedef enum logic [3:0] {
        CTGS_ACQ_BEGIN,
        CTGS_ACQ_FINISH,
        CTGS_ACQ_SPAN,
        CTGS_BURST_BEGIN,
        CTGS_BURST_FINISH,
        CTGS_BURST_SPAN,
        CTGS_FRM_BEGIN,
        CTGS_FRM_FINISH,
        CTGS_FRM_SPAN,
        CTGS_ROW_BEGIN,
        CTGS_EXPO_BEGIN,
        CTGS_EXPO_FINISH,
        CTGS_EXPO_SPAN
    } ctgs_trig_type;

    localparam int CTGS_NUM_TYPES = 13;

    typedef enum logic [2:0] {
        CTGS_SENSE_RISE,
        CTGS_SENSE_FALL,
        CTGS_SENSE_BOTH,
        CTGS_SENSE_HI,
        CTGS_SENSE_LO
    } ctgs_sense_type;

    typedef enum logic [1:0] {
        CTGS_OVERLAP_OFF,
        CTGS_OVERLAP_AFTER_EXPOSE,
        CTGS_OVERLAP_ANY_TIME
    } ctgs_overlap_type;

    typedef enum logic [2:0] {
        CTGS_ST_ACQ_WAIT,
        CTGS_ST_ACQ_RUNNING,
        CTGS_ST_ACQ_XFER,
        CTGS_ST_FRM_WAIT,
        CTGS_ST_FRM_RUNNING,
        CTGS_ST_EXPOSING,
        CTGS_ST_FRM_XFER_OLD
    } ctgs_status_type;

    typedef enum logic [1:0] {
        CTGS_CH_IDLE,
        CTGS_CH_WAIT,
        CTGS_CH_BURST
    } ctgs_chan_state_type;

    // source code 0 is software, hardware sources start at 1
    localparam logic [7:0] CTGS_SRC_SOFTWARE = 8'h00;
    localparam logic [7:0] CTGS_SRC_HW_BASE  = 8'h01;

    localparam int CTGS_WAIT_W = 16;
    localparam int CTGS_RATIO_W = 8;

    // reset values of the configuration store
    localparam logic [7:0]              CTGS_RST_SRC    = 8'h00;
    localparam logic [CTGS_WAIT_W-1:0]  CTGS_RST_WAIT   = 16'h0000;
    localparam logic [CTGS_RATIO_W-1:0] CTGS_RST_RATIO  = 8'h01;

endpackage

// >>> logic/ctgs_trig_chan.sv
// ctgs_trig_chan: one trigger channel: source pick, sensing, divide, multiply, delay.
// assumes hardware sources are already synchronous to clk_sys.
`timescale 1ns/1ps
module ctgs_trig_chan #(
    parameter int NSRC = 16
) (
    input  wire logic                                clk_sys,
    input  wire logic                                reset,
    input  wire logic                                enable,
    input  wire logic [7:0]                          srcCode,
    input  ctgs_pkg::ctgs_sense_type                 sense,
    input  wire logic [ctgs_pkg::CTGS_RATIO_W-1:0]   divRatio,
    input  wire logic [ctgs_pkg::CTGS_RATIO_W-1:0]   mulRatio,
    input  wire logic [ctgs_pkg::CTGS_WAIT_W-1:0]    waitTime,
    input  wire logic                                swPulse,
    input  wire logic [NSRC-1:0]                     hwSrc,
    output logic                                     validPulse,
    output logic                                     validLevel
);
    import ctgs_pkg::*;

    logic                    isSoftware;
    logic                    srcLvl;
    logic                    prevLvl_ff;
    logic                    rise;
    logic                    fall;
    logic                    hit;
    logic                    passDiv;
    logic [CTGS_RATIO_W-1:0] divCnt_ff;
    logic [CTGS_RATIO_W-1:0] burstCnt_ff;
    logic [CTGS_WAIT_W-1:0]  waitCnt_ff;
    ctgs_chan_state_type     state_ff;

    assign isSoftware = (srcCode == CTGS_SRC_SOFTWARE);

    always_comb begin
        srcLvl = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (srcCode == 8'(i + 1)) begin
                srcLvl = hwSrc[i];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prevLvl_ff <= 1'b0;
        end else begin
            prevLvl_ff <= srcLvl;
        end
    end

    assign rise = srcLvl & ~prevLvl_ff;
    assign fall = ~srcLvl & prevLvl_ff;

    // level modes also fire on the edge that makes them active so the pulse path is fed
    always_comb begin
        hit = 1'b0;
        if (enable) begin
            if (isSoftware) begin
                hit = swPulse;
            end else begin
                unique case (sense)
                    CTGS_SENSE_RISE: hit = rise;
                    CTGS_SENSE_FALL: hit = fall;
                    CTGS_SENSE_BOTH: hit = rise | fall;
                    CTGS_SENSE_HI:   hit = rise;
                    CTGS_SENSE_LO:   hit = fall;
                    default:         hit = 1'b0;
                endcase
            end
        end
    end

    always_comb begin
        validLevel = 1'b0;
        if (enable && !isSoftware) begin
            validLevel = (sense == CTGS_SENSE_HI) ? srcLvl :
                         (sense == CTGS_SENSE_LO) ? ~srcLvl : 1'b0;
        end
    end

    // divider: one in every divRatio hits passes; a ratio of zero acts as one
    assign passDiv = hit && ((divCnt_ff + 8'h01) >= divRatio);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            divCnt_ff <= 8'h00;
        end else if (!enable) begin
            divCnt_ff <= 8'h00;
        end else if (hit) begin
            divCnt_ff <= passDiv ? 8'h00 : divCnt_ff + 8'h01;
        end
    end

    // the delay is common to every multiplied pulse, so delaying the burst start
    // equals delaying each pulse; hits arriving while busy are dropped
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff    <= CTGS_CH_IDLE;
            waitCnt_ff  <= CTGS_RST_WAIT;
            burstCnt_ff <= 8'h00;
            validPulse  <= 1'b0;
        end else if (!enable) begin
            state_ff    <= CTGS_CH_IDLE;
            waitCnt_ff  <= CTGS_RST_WAIT;
            burstCnt_ff <= 8'h00;
            validPulse  <= 1'b0;
        end else begin
            validPulse <= 1'b0;
            unique case (state_ff)
                CTGS_CH_IDLE: begin
                    if (passDiv) begin
                        burstCnt_ff <= (mulRatio == 8'h00) ? 8'h01 : mulRatio;
                        waitCnt_ff  <= waitTime;
                        state_ff    <= (waitTime == CTGS_RST_WAIT) ? CTGS_CH_BURST
                                                                   : CTGS_CH_WAIT;
                    end
                end
                CTGS_CH_WAIT: begin
                    waitCnt_ff <= waitCnt_ff - 16'h0001;
                    if (waitCnt_ff == 16'h0001) begin
                        state_ff <= CTGS_CH_BURST;
                    end
                end
                CTGS_CH_BURST: begin
                    validPulse  <= 1'b1;
                    burstCnt_ff <= burstCnt_ff - 8'h01;
                    if (burstCnt_ff == 8'h01) begin
                        state_ff <= CTGS_CH_IDLE;
                    end
                end
                default: state_ff <= CTGS_CH_IDLE;
            endcase
        end
    end

endmodule // ctgs_trig_chan

// >>> logic/ctgs_trigger_gen.sv
// ctgs_trigger_gen: trigger generation for all trigger types plus acquisition status multiplexer.
// assumes the acquisition engine drives the state inputs and consumes trigPulse/trigLevel.
//
// Functional notes
// - status output shows the flag picked by the status selector.
// - acquisition-wait flag set while waiting for an acquisition trigger.
// - acquisition-running flag set during an acquisition.
// - acquisition-transfer flag set while acquisition data goes out.
// - frame-wait flag set while waiting for a frame start trigger.
// - frame-running flag set while capturing; exposing flag while exposing.
// - each trigger type configured independently, picked by the type selector.
// - each type has its own enable; disabled types never act.
// - sources: software, lines, counter/timer events, user outputs, actions.
// - software command yields one pulse for the selected type.
// - hardware sources sensed by rising, falling, either edge, high or low.
// - overlap policy decides when a new frame start is accepted.
// - programmable delay between trigger reception and action.
// - divider and multiplier scale accepted triggers.
// - stages in order: enable/sense, divide/multiply, delay, overlap.
// - triggers act only after an acquisition start command.
`timescale 1ns/1ps
module ctgs_trigger_gen #(
    parameter int NLINE = 4,
    parameter int NCNT  = 2,
    parameter int NTMR  = 2,
    parameter int NUSR  = 4,
    parameter int NACT  = 2
) (
    input  wire logic                                      clk_sys,
    input  wire logic                                      reset,
    // configuration, written into the type picked by trigTypePick
    input  wire logic                                      cfgWrite,
    input  ctgs_pkg::ctgs_trig_type                        trigTypePick,
    input  wire logic                                      trigEnable,
    input  wire logic [7:0]                                trigInputPick,
    input  ctgs_pkg::ctgs_sense_type                       trigSense,
    input  wire logic [ctgs_pkg::CTGS_WAIT_W-1:0]          trigWaitTime,
    input  wire logic [ctgs_pkg::CTGS_RATIO_W-1:0]         trigDiv,
    input  wire logic [ctgs_pkg::CTGS_RATIO_W-1:0]         trigMul,
    input  ctgs_pkg::ctgs_overlap_type                     trigOverlapPolicy,
    input  wire logic                                      swFire,
    // acquisition commands, one-cycle pulses
    input  wire logic                                      acqStartCmd,
    input  wire logic                                      acqStopCmd,
    // trigger sources
    input  wire logic [NLINE-1:0]                          lineIn,
    input  wire logic [NCNT-1:0]                           cntStart,
    input  wire logic [NCNT-1:0]                           cntEnd,
    input  wire logic [NTMR-1:0]                           tmrStart,
    input  wire logic [NTMR-1:0]                           tmrEnd,
    input  wire logic [NUSR-1:0]                           userOut,
    input  wire logic [NACT-1:0]                           actionIn,
    // internal acquisition state from the engine
    input  wire logic                                      acqWaitFlag,
    input  wire logic                                      acqRunning,
    input  wire logic                                      acqXferFlag,
    input  wire logic                                      frmWaitFlag,
    input  wire logic                                      frmRunning,
    input  wire logic                                      exposing,
    input  ctgs_pkg::ctgs_status_type                      acqStatePick,
    // results
    output logic [ctgs_pkg::CTGS_NUM_TYPES-1:0]            trigPulse,
    output logic [ctgs_pkg::CTGS_NUM_TYPES-1:0]            trigLevel,
    output logic                                           acqArmed,
    output logic                                           acqStateFlag
);
    import ctgs_pkg::*;

    localparam int NSRC = NLINE + 2 * NCNT + 2 * NTMR + NUSR + NACT;

    logic [NLINE-1:0]             lineMeta_ff;
    logic [NLINE-1:0]             lineSync_ff;
    logic [NSRC-1:0]              hwSrc;
    logic [CTGS_NUM_TYPES-1:0]    enable_ff;
    logic [7:0]                   src_ff      [CTGS_NUM_TYPES];
    ctgs_sense_type               sense_ff    [CTGS_NUM_TYPES];
    logic [CTGS_WAIT_W-1:0]       wait_ff     [CTGS_NUM_TYPES];
    logic [CTGS_RATIO_W-1:0]      div_ff      [CTGS_NUM_TYPES];
    logic [CTGS_RATIO_W-1:0]      mul_ff      [CTGS_NUM_TYPES];
    ctgs_overlap_type             overlap_ff;
    logic [CTGS_NUM_TYPES-1:0]    swPulse_ff;
    logic [CTGS_NUM_TYPES-1:0]    chanPulse;
    logic [CTGS_NUM_TYPES-1:0]    chanLevel;
    logic                         frmPending_ff;
    logic                         frmAccept;
    logic                         frmFire;

    // two-stage synchroniser on external lines; only the second stage is read
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lineMeta_ff <= '0;
            lineSync_ff <= '0;
        end else begin
            lineMeta_ff <= lineIn;
            lineSync_ff <= lineMeta_ff;
        end
    end

    // hardware source numbering: lines, counter start/end, timer start/end, user, action
    assign hwSrc = {actionIn, userOut, tmrEnd, tmrStart, cntEnd, cntStart, lineSync_ff};

    // per-type configuration store
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable_ff <= '0;
            for (int i = 0; i < CTGS_NUM_TYPES; i++) begin
                src_ff[i]   <= CTGS_RST_SRC;
                sense_ff[i] <= CTGS_SENSE_RISE;
                wait_ff[i]  <= CTGS_RST_WAIT;
                div_ff[i]   <= CTGS_RST_RATIO;
                mul_ff[i]   <= CTGS_RST_RATIO;
            end
        end else if (cfgWrite) begin
            enable_ff[trigTypePick] <= trigEnable;
            src_ff[trigTypePick]    <= trigInputPick;
            sense_ff[trigTypePick]  <= trigSense;
            wait_ff[trigTypePick]   <= trigWaitTime;
            div_ff[trigTypePick]    <= trigDiv;
            mul_ff[trigTypePick]    <= trigMul;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            overlap_ff <= CTGS_OVERLAP_OFF;
        end else if (cfgWrite && trigTypePick == CTGS_FRM_BEGIN) begin
            overlap_ff <= trigOverlapPolicy;
        end
    end

    // a software command only fires a type whose source is software; the host
    // must have picked that source first, otherwise the command is ignored
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            swPulse_ff <= '0;
        end else begin
            for (int i = 0; i < CTGS_NUM_TYPES; i++) begin
                swPulse_ff[i] <= swFire && (trigTypePick == ctgs_trig_type'(i))
                                 && (src_ff[i] == CTGS_SRC_SOFTWARE);
            end
        end
    end

    for (genvar g = 0; g < CTGS_NUM_TYPES; g++) begin : gChan
        ctgs_trig_chan #(
            .NSRC (NSRC)
        ) uChan (
            .clk_sys    (clk_sys),
            .reset      (reset),
            .enable     (enable_ff[g]),
            .srcCode    (src_ff[g]),
            .sense      (sense_ff[g]),
            .divRatio   (div_ff[g]),
            .mulRatio   (mul_ff[g]),
            .waitTime   (wait_ff[g]),
            .swPulse    (swPulse_ff[g]),
            .hwSrc      (hwSrc),
            .validPulse (chanPulse[g]),
            .validLevel (chanLevel[g])
        );
    end

    // armed by the acquisition start command, dropped by the stop command
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acqArmed <= 1'b0;
        end else if (acqStartCmd) begin
            acqArmed <= 1'b1;
        end else if (acqStopCmd) begin
            acqArmed <= 1'b0;
        end
    end

    // frame start overlap: last stage before the engine
    always_comb begin
        unique case (overlap_ff)
            CTGS_OVERLAP_OFF:          frmAccept = !frmRunning;
            CTGS_OVERLAP_AFTER_EXPOSE: frmAccept = !exposing;
            CTGS_OVERLAP_ANY_TIME:     frmAccept = !frmRunning;
            default:                   frmAccept = 1'b0;
        endcase
    end

    // any-time overlap latches one early trigger and releases it when the frame ends
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            frmPending_ff <= 1'b0;
        end else if (!enable_ff[CTGS_FRM_BEGIN] || !acqArmed
                     || overlap_ff != CTGS_OVERLAP_ANY_TIME) begin
            frmPending_ff <= 1'b0;
        end else if (chanPulse[CTGS_FRM_BEGIN] && !frmAccept) begin
            frmPending_ff <= 1'b1;
        end else if (frmAccept) begin
            frmPending_ff <= 1'b0;
        end
    end

    assign frmFire = frmAccept && (chanPulse[CTGS_FRM_BEGIN] || frmPending_ff);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trigPulse <= '0;
            trigLevel <= '0;
        end else begin
            for (int i = 0; i < CTGS_NUM_TYPES; i++) begin
                if (i == int'(CTGS_FRM_BEGIN)) begin
                    trigPulse[i] <= acqArmed && frmFire;
                end else begin
                    trigPulse[i] <= acqArmed && chanPulse[i];
                end
                trigLevel[i] <= acqArmed && chanLevel[i];
            end
        end
    end

    // status multiplexer; the deprecated frame-transfer choice reads false
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acqStateFlag <= 1'b0;
        end else begin
            unique case (acqStatePick)
                CTGS_ST_ACQ_WAIT:     acqStateFlag <= acqWaitFlag;
                CTGS_ST_ACQ_RUNNING:  acqStateFlag <= acqRunning;
                CTGS_ST_ACQ_XFER:     acqStateFlag <= acqXferFlag;
                CTGS_ST_FRM_WAIT:     acqStateFlag <= frmWaitFlag;
                CTGS_ST_FRM_RUNNING:  acqStateFlag <= frmRunning;
                CTGS_ST_EXPOSING:     acqStateFlag <= exposing;
                default:              acqStateFlag <= 1'b0;
            endcase
        end
    end

endmodule // ctgs_trigger_gen
